// file: hdl/ssmc_params.svh
// timing constants and counts for the service setting mode controller
`ifndef SSMC_PARAMS_SVH
`define SSMC_PARAMS_SVH

`define SSMC_CLK_NS        20
`define SSMC_TICK_NS       1000000
`define SSMC_TICK_CYCLES   (`SSMC_TICK_NS / `SSMC_CLK_NS)
`define SSMC_HOLD_MS       5000
`define SSMC_WIN_MS        20000
`define SSMC_DB_MS         20
`define SSMC_SAFE_MS       178000
`define SSMC_SAFE_TEST_MS  0
`define SSMC_FAN_MS        1600
`define SSMC_FAN_TEST_MS   0
`define SSMC_REV_MS        1000
`define SSMC_REV_TEST_MS   0
`define SSMC_DRY_MS        600000
`define SSMC_DRY_TEST_MS   60000
`define SSMC_RUN5_MS       300000
`define SSMC_RUN5_TEST_MS  30000
`define SSMC_RND_STEP_MS   1000
`define SSMC_RND_STEP_TEST 100
`define SSMC_RND_MAX       62
`define SSMC_TMR_N         6
`define SSMC_TMR_W         20
`define SSMC_LFSR_SEED     8'hA5

`endif

// file: hdl/ssmc_pkg.sv
// types shared by the service setting mode controller
package ssmc_pkg;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_H1   = 5'h02,
        S_W2   = 5'h04,
        S_H2   = 5'h08,
        S_SET  = 5'h10
    } ssmc_state_t;

    typedef struct packed {
        logic short_b;
        logic long_b;
        logic double_b;
    } ssmc_beep_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] code;
        logic       stop;
    } ssmc_frame_t;

    // bit order matches the timer index used in the generate loop
    typedef struct packed {
        logic run5;
        logic dry_on;
        logic rev_det;
        logic fan_dly;
        logic rnd_restart;
        logic safe_dly;
    } ssmc_tmr_t;

endpackage

// file: hdl/ssmc_timer.sv
// one-shot millisecond down counter with level done flag
`timescale 1ns/1ps
`include "ssmc_params.svh"

module ssmc_timer #(
    parameter int W = `SSMC_TMR_W
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         tick,
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    output logic              done_q
);

    logic [W-1:0] cnt_q;
    logic         run_q;

    // done holds until the next start so the consumer may sample it late
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end
        else if (start)
        begin
            cnt_q  <= load;
            run_q  <= (load != '0);
            done_q <= (load == '0);
        end
        else if (run_q && tick)
        begin
            cnt_q <= cnt_q - W'(1);
            if (cnt_q == W'(1))
            begin
                run_q  <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end

    chk_zero_load_done: assert property (@(posedge clk) disable iff (!rst_n)
        start && (load == '0) |=> done_q && !run_q)
        else $error("zero load did not finish at once");

endmodule

// file: hdl/ssmc_ctrl.sv
// service button, setting mode, remote code filter and test-scaled timers
`timescale 1ns/1ps
`include "ssmc_params.svh"

module ssmc_ctrl #(
    parameter int TICK_CYCLES = `SSMC_TICK_CYCLES,
    parameter int HOLD_MS     = `SSMC_HOLD_MS,
    parameter int WIN_MS      = `SSMC_WIN_MS,
    parameter int DB_MS       = `SSMC_DB_MS,
    parameter int REV_MS      = `SSMC_REV_MS
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 svc_btn,
    input  wire logic                 test_short,
    input  wire ssmc_pkg::ssmc_frame_t rx_frame,
    input  wire logic [1:0]           nvm_rd_code,
    input  wire ssmc_pkg::ssmc_tmr_t  tmr_start,
    output ssmc_pkg::ssmc_tmr_t       tmr_done,
    output ssmc_pkg::ssmc_beep_t      beep_q,
    output logic                      forced_cool_q,
    output logic                      setting_mode_q,
    output logic                      ack_en_q,
    output logic [1:0]                code_q,
    output logic                      nvm_we_q,
    output logic [1:0]                nvm_wcode_q,
    output logic                      accept_q,
    output logic                      accept_stop_q
);

    localparam int N = `SSMC_TMR_N;
    localparam int W = `SSMC_TMR_W;

    ssmc_pkg::ssmc_state_t st_q;
    logic [15:0]  div_q;
    logic         tick;
    logic         sync1_q;
    logic         sync2_q;
    logic         db_q;
    logic         db_prev_q;
    logic [7:0]   db_cnt_q;
    logic [15:0]  hold_q;
    logic [15:0]  win_q;
    logic         test_q;
    logic         loaded_q;
    logic [7:0]   lfsr_q;
    logic         press_rise;
    logic         hold_hit;
    logic         win_exp;
    logic         set_frame;
    logic [5:0]   rnd;
    logic [N-1:0] start_v;
    logic [N-1:0] done_v;
    logic [W-1:0] load_v [N];

    assign tick       = (div_q == 16'(TICK_CYCLES - 1));
    assign press_rise = db_q && !db_prev_q;
    assign hold_hit   = db_q && tick && (hold_q == 16'(HOLD_MS - 1));
    assign win_exp    = tick && (win_q == 16'(WIN_MS - 1));
    assign set_frame  = (st_q == ssmc_pkg::S_SET) && rx_frame.valid;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || tick)
            div_q <= 16'h0000;
        else
            div_q <= div_q + 16'h0001;
    end

    // the raw button never reaches anything but the first stage
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sync1_q   <= 1'b0;
            sync2_q   <= 1'b0;
            db_q      <= 1'b0;
            db_prev_q <= 1'b0;
            db_cnt_q  <= 8'h00;
        end
        else
        begin
            sync1_q   <= svc_btn;
            sync2_q   <= sync1_q;
            db_prev_q <= db_q;
            if (sync2_q == db_q)
                db_cnt_q <= 8'h00;
            else if (tick)
            begin
                if (db_cnt_q == 8'(DB_MS - 1))
                begin
                    db_q     <= sync2_q;
                    db_cnt_q <= 8'h00;
                end
                else
                    db_cnt_q <= db_cnt_q + 8'h01;
            end
        end
    end

    // hold length saturates so one long press gives one hit only
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || !db_q)
            hold_q <= 16'h0000;
        else if (tick && hold_q != 16'(HOLD_MS))
            hold_q <= hold_q + 16'h0001;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            win_q <= 16'h0000;
        else if ((st_q == ssmc_pkg::S_H1 && !db_q) || (st_q == ssmc_pkg::S_H2 && !db_q))
            win_q <= 16'h0000;
        else if (st_q == ssmc_pkg::S_SET && press_rise)
            win_q <= 16'h0000;
        else if (tick)
            win_q <= win_q + 16'h0001;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            st_q          <= ssmc_pkg::S_IDLE;
            beep_q        <= '0;
            forced_cool_q <= 1'b0;
            ack_en_q      <= 1'b1;
        end
        else
        begin
            beep_q        <= '0;
            forced_cool_q <= 1'b0;
            if (accept_q && ack_en_q)
            begin
                beep_q.long_b  <= accept_stop_q;
                beep_q.short_b <= !accept_stop_q;
            end
            case (st_q)
                ssmc_pkg::S_IDLE:
                    if (hold_hit)
                    begin
                        st_q           <= ssmc_pkg::S_H1;
                        beep_q.short_b <= 1'b1;
                    end
                ssmc_pkg::S_H1:
                    if (!db_q)
                    begin
                        st_q          <= ssmc_pkg::S_W2;
                        forced_cool_q <= 1'b1;
                    end
                ssmc_pkg::S_W2:
                    if (hold_hit)
                    begin
                        st_q            <= ssmc_pkg::S_H2;
                        beep_q.double_b <= 1'b1;
                    end
                    else if (win_exp)
                        st_q <= ssmc_pkg::S_IDLE;
                ssmc_pkg::S_H2:
                    if (!db_q)
                        st_q <= ssmc_pkg::S_SET;
                ssmc_pkg::S_SET:
                    if (rx_frame.valid)
                        st_q <= ssmc_pkg::S_IDLE;
                    else if (press_rise)
                    begin
                        ack_en_q       <= !ack_en_q;
                        beep_q.short_b <= !ack_en_q;
                        beep_q.long_b  <= ack_en_q;
                    end
                    else if (win_exp)
                        st_q <= ssmc_pkg::S_IDLE;
                default:
                    st_q <= ssmc_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            setting_mode_q <= 1'b0;
        else
            setting_mode_q <= (st_q == ssmc_pkg::S_H2 && !db_q) ||
                              (st_q == ssmc_pkg::S_SET && !rx_frame.valid && !(win_exp && !press_rise));
    end

    // stored code is fetched once after reset, later only written through
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            loaded_q    <= 1'b0;
            code_q      <= 2'h0;
            nvm_we_q    <= 1'b0;
            nvm_wcode_q <= 2'h0;
        end
        else
        begin
            loaded_q <= 1'b1;
            nvm_we_q <= set_frame;
            if (!loaded_q)
                code_q <= nvm_rd_code;
            else if (set_frame)
            begin
                code_q      <= rx_frame.code;
                nvm_wcode_q <= rx_frame.code;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            accept_q      <= 1'b0;
            accept_stop_q <= 1'b0;
        end
        else
        begin
            accept_q      <= rx_frame.valid && loaded_q && st_q != ssmc_pkg::S_SET &&
                             rx_frame.code == code_q;
            accept_stop_q <= rx_frame.stop;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            test_q <= 1'b0;
            lfsr_q <= `SSMC_LFSR_SEED;
        end
        else
        begin
            test_q <= test_short;
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        end
    end

    assign rnd = (lfsr_q[5:0] > 6'(`SSMC_RND_MAX)) ? 6'(`SSMC_RND_MAX) : lfsr_q[5:0];

    // a load is picked when its timer starts; later test point changes wait for the next start
    always_comb
    begin
        load_v[0] = test_q ? W'(`SSMC_SAFE_TEST_MS) : W'(`SSMC_SAFE_MS);
        load_v[1] = W'({14'h0000, rnd} * (test_q ? W'(`SSMC_RND_STEP_TEST)
                                                 : W'(`SSMC_RND_STEP_MS)));
        load_v[2] = test_q ? W'(`SSMC_FAN_TEST_MS) : W'(`SSMC_FAN_MS);
        load_v[3] = test_q ? W'(`SSMC_REV_TEST_MS) : W'(REV_MS);
        load_v[4] = test_q ? W'(`SSMC_DRY_TEST_MS) : W'(`SSMC_DRY_MS);
        load_v[5] = test_q ? W'(`SSMC_RUN5_TEST_MS) : W'(`SSMC_RUN5_MS);
    end

    assign start_v  = tmr_start;
    assign tmr_done = done_v;

    for (genvar i = 0; i < N; i++)
    begin : g_tmr
        ssmc_timer #(.W(W)) u_tmr (
            .clk    (ref_clk),
            .rst_n  (rst_n),
            .tick   (tick),
            .start  (start_v[i]),
            .load   (load_v[i]),
            .done_q (done_v[i])
        );
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_press_in_set;
        st_q == ssmc_pkg::S_SET && press_rise && !rx_frame.valid;
    endsequence

    sequence s_second_hold;
        st_q == ssmc_pkg::S_W2 && hold_hit;
    endsequence

    chk_first_hold_beep: assert property (st_q == ssmc_pkg::S_IDLE && hold_hit |=>
        st_q == ssmc_pkg::S_H1 && beep_q.short_b && !forced_cool_q)
        else $error("first hold gave no beep");
    chk_forced_release: assert property (forced_cool_q |->
        $past(st_q) == ssmc_pkg::S_H1 && !$past(db_q) && st_q == ssmc_pkg::S_W2)
        else $error("forced cooling without held release");
    chk_second_hold: assert property (s_second_hold |=>
        st_q == ssmc_pkg::S_H2 && beep_q.double_b)
        else $error("second hold gave no double beep");
    chk_setting_entry: assert property (st_q == ssmc_pkg::S_H2 && !db_q |=>
        st_q == ssmc_pkg::S_SET && setting_mode_q)
        else $error("setting mode not entered after second hold");
    chk_timeout_exit: assert property (st_q == ssmc_pkg::S_SET && win_exp && !press_rise &&
        !rx_frame.valid |=> st_q == ssmc_pkg::S_IDLE && !setting_mode_q)
        else $error("setting mode outlived its timeout");
    chk_ack_toggle: assert property (s_press_in_set |=>
        ack_en_q != $past(ack_en_q) && beep_q.short_b == ack_en_q && beep_q.long_b == !ack_en_q)
        else $error("acknowledge sound toggle wrong");
    chk_timer_restart: assert property (s_press_in_set |=> win_q == 16'h0000)
        else $error("setting timeout not restarted");
    chk_code_store: assert property (set_frame |=> nvm_we_q &&
        nvm_wcode_q == $past(rx_frame.code) && code_q == $past(rx_frame.code) && st_q == ssmc_pkg::S_IDLE)
        else $error("setting frame code not stored");
    chk_frame_filter: assert property (accept_q |->
        $past(rx_frame.valid) && $past(rx_frame.code) == $past(code_q) && $past(st_q) != ssmc_pkg::S_SET)
        else $error("frame accepted with wrong code");
    chk_accept_beep: assert property (accept_q && ack_en_q && st_q == ssmc_pkg::S_IDLE &&
        !hold_hit |=> beep_q.long_b == $past(accept_stop_q) && beep_q.short_b == !$past(accept_stop_q))
        else $error("accept beep kind wrong");
    chk_test_safe_zero: assert property (test_q && start_v[0] |=> done_v[0])
        else $error("safety delay not zero in test mode");

endmodule

// file: testbench/ssmc_panel.sv
// front panel button and infrared remote model facing the controller
`timescale 1ns/1ps

module ssmc_panel #(
    parameter int TICK_CYCLES = 10
) (
    input  wire logic              ref_clk,
    output logic                   svc_btn,
    output ssmc_pkg::ssmc_frame_t  rx_frame
);
    initial
    begin
        svc_btn  = 1'b0;
        rx_frame = '0;
    end

    task automatic wait_ms(input int ms);
        repeat (ms * TICK_CYCLES) @(posedge ref_clk);
    endtask

    // clean press held for hold_ms, then idle for gap_ms
    task automatic press(input int hold_ms, input int gap_ms);
        @(posedge ref_clk);
        svc_btn <= 1'b1;
        wait_ms(hold_ms);
        svc_btn <= 1'b0;
        wait_ms(gap_ms);
    endtask

    // code stands for the jumper choice; the remote sends one frame per key and its own
    // code-setting mode ends with that send, on cancel, or after its 30 s limit
    task automatic send(input logic [1:0] code, input logic stop);
        @(posedge ref_clk);
        rx_frame <= '{valid: 1'b1, code: code, stop: stop};
        @(posedge ref_clk);
        // a finished frame drops valid and leaves the inverted code and stop bit behind
        rx_frame <= '{valid: 1'b0, code: ~code, stop: ~stop};
        repeat (4) @(posedge ref_clk);
    endtask
endmodule

// file: testbench/test_ssmc_ctrl.sv
// self-checking bench for the service setting mode controller
`timescale 1ns/1ps

module test_ssmc_ctrl;
    localparam int TICK = 10;
    logic                  ref_clk = 1'b0;
    logic                  rst_n;
    logic                  svc_btn;
    logic                  test_short;
    ssmc_pkg::ssmc_frame_t rx_frame;
    logic [1:0]            nvm_rd_code = 2'h1;
    ssmc_pkg::ssmc_tmr_t   tmr_start;
    ssmc_pkg::ssmc_tmr_t   tmr_done;
    ssmc_pkg::ssmc_beep_t  beep_q;
    logic                  forced_cool_q;
    logic                  setting_mode_q;
    logic                  ack_en_q;
    logic [1:0]            code_q;
    logic                  nvm_we_q;
    logic [1:0]            nvm_wcode_q;
    logic                  accept_q;
    logic                  accept_stop_q;
    int                    error_cnt = 0;
    int                    comparisons = 0;
    int                    cycles = 0;
    int                    wait_cyc = 0;
    int                    n [6] = '{default: 0};
    int                    b [6];

    always #10 ref_clk = ~ref_clk;

    ssmc_ctrl #(.TICK_CYCLES(TICK), .HOLD_MS(20), .WIN_MS(60), .DB_MS(2)) ssmc_ctrl_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .svc_btn(svc_btn), .test_short(test_short),
        .rx_frame(rx_frame), .nvm_rd_code(nvm_rd_code), .tmr_start(tmr_start), .tmr_done(tmr_done),
        .beep_q(beep_q), .forced_cool_q(forced_cool_q), .setting_mode_q(setting_mode_q),
        .ack_en_q(ack_en_q), .code_q(code_q), .nvm_we_q(nvm_we_q), .nvm_wcode_q(nvm_wcode_q),
        .accept_q(accept_q), .accept_stop_q(accept_stop_q));

    ssmc_panel #(.TICK_CYCLES(TICK)) ssmc_panel_i (
        .ref_clk(ref_clk), .svc_btn(svc_btn), .rx_frame(rx_frame));

    // non-volatile store: keeps the last written code across resets
    always @(posedge ref_clk)
    begin
        if (nvm_we_q === 1'b1)
            nvm_rd_code <= nvm_wcode_q;
    end

    // pulse tallies: short, long, double, forced cooling, accept, nvm write
    always @(posedge ref_clk)
    begin
        n[0] += int'(beep_q.short_b === 1'b1);
        n[1] += int'(beep_q.long_b === 1'b1);
        n[2] += int'(beep_q.double_b === 1'b1);
        n[3] += int'(forced_cool_q === 1'b1);
        n[4] += int'(accept_q === 1'b1);
        n[5] += int'(nvm_we_q === 1'b1);
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // worst case run is about 82k cycles, mostly the random restart wait
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            error_cnt++;
            $display("CHECK FAILED run time expected below 95000 cycles seen %0d", cycles);
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic pulses(input string what, input int idx, input int exp);
        check(what, 16'(exp), 16'(n[idx] - b[idx]));
    endtask

    task automatic pulse_start(input logic [5:0] sel);
        @(posedge ref_clk);
        tmr_start <= sel;
        @(posedge ref_clk);
        tmr_start <= '0;
    endtask

    task automatic enter_setting();
        ssmc_panel_i.press(25, 5);
        ssmc_panel_i.press(25, 5);
    endtask

    initial
    begin
        rst_n       = 1'b0;
        test_short  = 1'b0;
        tmr_start   = '0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("ack enable after reset", 16'h0001, 16'(ack_en_q));
        check("code loaded from nvm", 16'h0001, 16'(code_q));
        b = n;
        ssmc_panel_i.send(2'h2, 1'b0);
        ssmc_panel_i.send(2'h1, 1'b0);
        ssmc_panel_i.send(2'h1, 1'b1);
        pulses("accepted frames", 4, 2);
        pulses("short beeps on set", 0, 1);
        pulses("long beeps on stop", 1, 1);
        $display("test remote filter done");

        b = n;
        ssmc_panel_i.press(10, 10);
        pulses("beeps after short hold", 0, 0);
        ssmc_panel_i.press(25, 5);
        pulses("beep at hold time", 0, 1);
        pulses("forced cooling starts", 3, 1);
        ssmc_panel_i.wait_ms(65);
        ssmc_panel_i.press(25, 5);
        check("late second hold", 16'h0000, 16'(setting_mode_q));
        ssmc_panel_i.press(25, 5);
        pulses("double beep", 2, 1);
        check("setting mode entered", 16'h0001, 16'(setting_mode_q));
        $display("test button holds done");

        b = n;
        ssmc_panel_i.press(5, 5);
        check("sound toggled off", 16'h0000, 16'(ack_en_q));
        pulses("long beep on disable", 1, 1);
        ssmc_panel_i.press(5, 5);
        check("sound toggled on", 16'h0001, 16'(ack_en_q));
        pulses("short beep on enable", 0, 1);
        ssmc_panel_i.wait_ms(45);
        check("timeout restarted by press", 16'h0001, 16'(setting_mode_q));
        ssmc_panel_i.wait_ms(15);
        check("setting mode timed out", 16'h0000, 16'(setting_mode_q));
        $display("test setting timeout done");

        enter_setting();
        ssmc_panel_i.press(5, 5);
        b = n;
        ssmc_panel_i.send(2'h3, 1'b0);
        pulses("nvm write", 5, 1);
        check("nvm write code", 16'h0003, 16'(nvm_wcode_q));
        check("stored code", 16'h0003, 16'(code_q));
        check("setting mode left", 16'h0000, 16'(setting_mode_q));
        b = n;
        ssmc_panel_i.send(2'h1, 1'b0);
        ssmc_panel_i.send(2'h3, 1'b1);
        pulses("accepted with new code", 4, 1);
        pulses("silent long beep", 1, 0);
        pulses("silent short beep", 0, 0);
        $display("test code learning done");

        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("code kept over power loss", 16'h0003, 16'(code_q));
        check("ack enable after second reset", 16'h0001, 16'(ack_en_q));
        check("idle after second reset", 16'h0000, 16'(setting_mode_q));
        $display("test power loss done");

        test_short <= 1'b1;
        repeat (3) @(posedge ref_clk);
        pulse_start(6'h0D);
        repeat (2) @(posedge ref_clk);
        check("safety delay zero", 16'h0001, 16'(tmr_done.safe_dly));
        check("fan delay zero", 16'h0001, 16'(tmr_done.fan_dly));
        check("reverse wait zero", 16'h0001, 16'(tmr_done.rev_det));
        pulse_start(6'h30);
        @(negedge ref_clk);
        check("soft dry load scaled", 16'(60000), 16'(ssmc_ctrl_i.g_tmr[4].u_tmr.cnt_q));
        check("run qualifier load scaled", 16'(30000), 16'(ssmc_ctrl_i.g_tmr[5].u_tmr.cnt_q));
        pulse_start(6'h02);
        wait_cyc = 0;
        while (tmr_done.rnd_restart !== 1'b1 && wait_cyc < 6200 * TICK + 2)
        begin
            @(posedge ref_clk);
            wait_cyc++;
        end
        check("random restart in scaled range", 16'h0001, 16'(tmr_done.rnd_restart));
        test_short <= 1'b0;
        repeat (3) @(posedge ref_clk);
        pulse_start(6'h35);
        @(negedge ref_clk);
        check("soft dry load", 16'(600000 >> 4), 16'(ssmc_ctrl_i.g_tmr[4].u_tmr.cnt_q >> 4));
        check("run qualifier load", 16'(300000 >> 4), 16'(ssmc_ctrl_i.g_tmr[5].u_tmr.cnt_q >> 4));
        ssmc_panel_i.wait_ms(1590);
        check("fan delay still running", 16'h0000, 16'(tmr_done.fan_dly));
        ssmc_panel_i.wait_ms(20);
        check("fan delay expired", 16'h0001, 16'(tmr_done.fan_dly));
        check("safety delay running", 16'h0000, 16'(tmr_done.safe_dly));
        $display("test timers done");
        print_verdict();
    end
endmodule
